// File: bench/ibr_bus_model.sv
module ibr_bus_model (
  // Device pin drive, high pulls the line low
  input  wire logic scl_oe,
  input  wire logic sda_oe,
  // Far-side device pulls data low (acknowledge or data bit)
  input  wire logic pull_sda,
  // Wired-AND line levels with pull-ups
  output logic      scl_line,
  output logic      sda_line
);
  timeunit 1ns;
  timeprecision 1ps;

  // Open drain: released lines float to the pull-up level
  assign scl_line = ~scl_oe;
  assign sda_line = ~(sda_oe | pull_sda);
endmodule

// File: bench/tb_i2c_bit_rate_and_hold_timing.sv
module tb_i2c_bit_rate_and_hold_timing;
  timeunit 1ns;
  timeprecision 1ps;

  // ----------------------------------------
  // Expected divider and hold values per code
  // ----------------------------------------
  localparam int DIVT [32] = '{20,22,24,26,28,30,34,40,28,32,36,40,44,48,
    56,68,48,56,64,72,80,88,104,128,80,96,112,128,144,160,192,240};
  localparam int SDAT [32] = '{7,7,8,8,9,9,10,10,7,7,9,9,11,11,13,13,9,9,
    13,13,17,17,21,21,9,9,17,17,25,25,33,33};
  localparam int STHT [32] = '{6,7,8,9,10,11,13,16,10,12,14,16,18,20,24,
    30,18,22,26,30,34,38,46,58,38,46,54,62,70,78,94,118};
  localparam int SPHT [32] = '{11,12,13,14,15,16,18,21,15,17,19,21,23,25,
    29,35,25,29,33,37,41,45,53,65,41,49,57,65,73,81,97,121};

  logic       clk = 1'b0;
  logic       reset_n = 1'b0;
  logic       ce = 1'b1;
  logic [1:0] reg_addr = 2'h0;
  logic [7:0] reg_wdata = 8'h00;
  logic       reg_wr = 1'b0;
  logic       reg_rd = 1'b0;
  logic [7:0] reg_rdata;
  logic       cmd_valid = 1'b0;
  logic [1:0] cmd_op = 2'h0;
  logic       cmd_data = 1'b0;
  logic       cmd_ready;
  logic       rx_bit;
  logic [6:0] rx_addr = 7'h00;
  logic       addr_match;
  logic       scl_in;
  logic       scl_out;
  logic       scl_oe;
  logic       sda_in;
  logic       sda_out;
  logic       sda_oe;
  logic       pull_sda = 1'b0;
  logic [7:0] own = 8'h00;
  logic [6:0] ra;
  logic       p_scl = 1'b0;
  logic       p_sda = 1'b0;
  int         bad_count = 0;
  int         comparisons = 0;
  int         cyc = 0;
  int         e_sda_on, e_sda_off, e_scl_on, e_scl_off;

  ibr_timing dut_u (
    .clk(clk), .reset_n(reset_n), .ce(ce),
    .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr),
    .reg_rd(reg_rd), .reg_rdata(reg_rdata),
    .cmd_valid(cmd_valid), .cmd_op(cmd_op), .cmd_data(cmd_data),
    .cmd_ready(cmd_ready), .rx_bit(rx_bit),
    .rx_addr(rx_addr), .addr_match(addr_match),
    .scl_in(scl_in), .scl_out(scl_out), .scl_oe(scl_oe),
    .sda_in(sda_in), .sda_out(sda_out), .sda_oe(sda_oe)
  );

  ibr_bus_model bus_u (
    .scl_oe(scl_oe), .sda_oe(sda_oe), .pull_sda(pull_sda),
    .scl_line(scl_in), .sda_line(sda_in)
  );

  always #5 clk = ~clk;
  always @(posedge clk) cyc <= cyc + 1;

  // ----------------------------------------
  // Edge index of each pin-drive transition
  // ----------------------------------------
  // Sampled mid-cycle so the index equals the launching edge count
  always @(negedge clk) begin
    if (sda_oe === 1'b1 && p_sda === 1'b0) e_sda_on = cyc;
    if (sda_oe === 1'b0 && p_sda === 1'b1) e_sda_off = cyc;
    if (scl_oe === 1'b1 && p_scl === 1'b0) e_scl_on = cyc;
    if (scl_oe === 1'b0 && p_scl === 1'b1) e_scl_off = cyc;
    p_sda = sda_oe;
    p_scl = scl_oe;
  end

  // ----------------------------------------
  // Compare, bus and command tasks
  // ----------------------------------------
  task automatic chk8(input logic [7:0] got, input logic [7:0] exp);
    comparisons++;
    if (got !== exp) begin
      bad_count++;
      $display("[FAIL] %0t register data %h expected %h", $time, got, exp);
    end
  endtask

  task automatic chk1(input logic got, input logic exp);
    comparisons++;
    if (got !== exp) begin
      bad_count++;
      $display("[FAIL] %0t flag %b expected %b", $time, got, exp);
    end
  endtask

  task automatic chkn(input int got, input int exp);
    comparisons++;
    if (got != exp) begin
      bad_count++;
      $display("[FAIL] %0t cycle count %0d expected %0d", $time, got, exp);
    end
  endtask

  function automatic int mulf(input logic [1:0] mc);
    case (mc)
      2'h1: mulf = 2;
      2'h2: mulf = 4;
      default: mulf = 1;
    endcase
  endfunction

  task automatic wr(input logic [1:0] a, input logic [7:0] d);
    @(posedge clk);
    reg_wr    <= 1'b1;
    reg_addr  <= a;
    reg_wdata <= d;
    @(posedge clk);
    reg_wr <= 1'b0;
  endtask

  task automatic rd(input logic [1:0] a, input logic [7:0] exp);
    @(posedge clk);
    reg_rd   <= 1'b1;
    reg_addr <= a;
    @(posedge clk);
    reg_rd <= 1'b0;
    @(negedge clk);
    chk8(reg_rdata, exp);
  endtask

  // Holds valid across commands so a pending one can go back to back
  task automatic send(input logic [1:0] op, input logic d, output int acc);
    int n;
    @(posedge clk);
    cmd_valid <= 1'b1;
    cmd_op    <= op;
    cmd_data  <= d;
    n = 0;
    do begin
      @(negedge clk);
      n++;
    end while (cmd_ready !== 1'b1 && n < 20000);
    if (cmd_ready !== 1'b1) bad_count++;
    acc = cyc + 1;
    @(posedge clk);
  endtask

  task automatic frame(input logic [1:0] mc, input logic [5:0] code);
    int a0, a1, a2, a3, m, p, k;
    logic pv;
    m = mulf(mc);
    p = m * DIVT[code];
    wr(ibr_pkg::OFS_RATE, {mc, code});
    rd(ibr_pkg::OFS_RATE, {mc, code});
    // Valid drops after a start so park does not take it again
    send(ibr_pkg::IBR_CMD_START, 1'b0, a0);
    cmd_valid <= 1'b0;
    k = 0;
    do begin
      @(negedge clk);
      k++;
    end while (scl_oe !== 1'b1 && k < 5000);
    if (scl_oe !== 1'b1) bad_count++;
    repeat (6) @(posedge clk);
    chkn(e_scl_on - e_sda_on, m * STHT[code]);
    rd(ibr_pkg::OFS_STATUS, 8'h00);
    chk1(scl_out | sda_out, 1'b0);
    // Repeated start from park: release, high phase, then a new start
    send(ibr_pkg::IBR_CMD_START, 1'b0, a0);
    cmd_valid <= 1'b0;
    k = 0;
    do begin
      @(negedge clk);
      k++;
    end while (cmd_ready !== 1'b1 && k < 5000);
    if (cmd_ready !== 1'b1) bad_count++;
    @(posedge clk);
    chkn(e_sda_off - a0, m * SDAT[code]);
    chkn(e_sda_on - a0, p);
    chkn(e_scl_on - e_sda_on, m * STHT[code]);
    send(ibr_pkg::IBR_CMD_BIT, 1'b1, a1);
    pv = 1'($urandom_range(1, 0));
    pull_sda <= pv;
    send(ibr_pkg::IBR_CMD_BIT, 1'b0, a2);
    pull_sda <= 1'b0;
    chkn(e_sda_off - a1, m * SDAT[code]);
    chkn(e_scl_off - a1, p / 2);
    chkn(a2 - a1, p);
    @(negedge clk);
    chk1(rx_bit, ~pv);
    send(ibr_pkg::IBR_CMD_STOP, 1'b0, a3);
    cmd_valid <= 1'b0;
    chkn(e_sda_on - a2, m * SDAT[code]);
    chkn(a3 - a2, p);
    k = 0;
    do begin
      @(negedge clk);
      k++;
    end while (sda_oe !== 1'b0 && k < 5000);
    if (sda_oe !== 1'b0) bad_count++;
    repeat (6) @(posedge clk);
    chkn(e_scl_off - a3, p / 2);
    chkn(e_sda_off - e_scl_off, m * SPHT[code]);
    rd(ibr_pkg::OFS_STATUS, 8'h07);
  endtask

  task automatic print_verdict();
    if (bad_count == 0 && comparisons > 0) begin
      $display("Finished cleanly");
    end else begin
      $display("Finished with errors");
    end
    $finish;
  endtask

  // ----------------------------------------
  // Watchdog
  // ----------------------------------------
  // Longest frame is a few thousand cycles; ample margin for ten
  initial begin
    repeat (100000) @(posedge clk);
    bad_count++;
    print_verdict();
  end

  // ----------------------------------------
  // Main sequence
  // ----------------------------------------
  initial begin
    void'($urandom(32'h19cdbd0c));
    repeat (5) @(posedge clk);
    reset_n <= 1'b1;
    rd(ibr_pkg::OFS_OWN_ADDR, ibr_pkg::OWN_ADDR_RST);
    rd(ibr_pkg::OFS_RATE, ibr_pkg::RATE_RST);
    rd(ibr_pkg::OFS_STATUS, 8'h07);
    rd(2'h3, 8'h00);
    for (int j = 0; j < 2; j++) begin
      own = (j == 0) ? 8'hff : 8'($urandom);
      wr(ibr_pkg::OFS_OWN_ADDR, own);
      rx_addr <= own[7:1];
      rd(ibr_pkg::OFS_OWN_ADDR, own & 8'hfe);
      for (int i = 0; i < 24; i++) begin
        ra = (i % 3 == 0) ? own[7:1] : 7'($urandom);
        @(posedge clk);
        rx_addr <= ra;
        @(posedge clk);
        @(negedge clk);
        chk1(addr_match, ra == own[7:1]);
      end
    end
    wr(2'h3, 8'h5a);
    rd(2'h3, 8'h00);
    rd(ibr_pkg::OFS_OWN_ADDR, own & 8'hfe);
    // Clock enable low must freeze the register write
    @(posedge clk);
    ce <= 1'b0;
    wr(ibr_pkg::OFS_OWN_ADDR, ~own);
    ce <= 1'b1;
    rd(ibr_pkg::OFS_OWN_ADDR, own & 8'hfe);
    frame(2'h0, 6'h00);
    frame(2'h2, 6'h1f);
    frame(2'h1, 6'h07);
    frame(2'h3, 6'h0b);
    for (int i = 0; i < 6; i++) begin
      frame(2'($urandom_range(2, 0)), 6'($urandom_range(31, 0)));
    end
    print_verdict();
  end
endmodule

// File: core/ibr_timing.sv
// Our own choices: the register addresses and the plain strobed port.
module ibr_timing (
  // Clock, reset, enable
  input  wire logic       clk,
  input  wire logic       reset_n,
  input  wire logic       ce,
  // Register port
  input  wire logic [1:0] reg_addr,
  input  wire logic [7:0] reg_wdata,
  input  wire logic       reg_wr,
  input  wire logic       reg_rd,
  output logic      [7:0] reg_rdata,
  // Bit commands
  input  wire logic       cmd_valid,
  input  wire logic [1:0] cmd_op,
  input  wire logic       cmd_data,
  output logic            cmd_ready,
  output logic            rx_bit,
  // Address matching
  input  wire logic [6:0] rx_addr,
  output logic            addr_match,
  // Bus pins
  input  wire logic       scl_in,
  output logic            scl_out,
  output logic            scl_oe,
  input  wire logic       sda_in,
  output logic            sda_out,
  output logic            sda_oe
);

  // ------------------------------------------------------------
  // Divider and hold table: {div, sda hold, start hold, stop hold}
  // ------------------------------------------------------------
  localparam logic [43:0] RATE_TBL [64] = '{
    {12'h014, 10'h007, 11'h006, 11'h00b},
    {12'h016, 10'h007, 11'h007, 11'h00c},
    {12'h018, 10'h008, 11'h008, 11'h00d},
    {12'h01a, 10'h008, 11'h009, 11'h00e},
    {12'h01c, 10'h009, 11'h00a, 11'h00f},
    {12'h01e, 10'h009, 11'h00b, 11'h010},
    {12'h022, 10'h00a, 11'h00d, 11'h012},
    {12'h028, 10'h00a, 11'h010, 11'h015},
    {12'h01c, 10'h007, 11'h00a, 11'h00f},
    {12'h020, 10'h007, 11'h00c, 11'h011},
    {12'h024, 10'h009, 11'h00e, 11'h013},
    {12'h028, 10'h009, 11'h010, 11'h015},
    {12'h02c, 10'h00b, 11'h012, 11'h017},
    {12'h030, 10'h00b, 11'h014, 11'h019},
    {12'h038, 10'h00d, 11'h018, 11'h01d},
    {12'h044, 10'h00d, 11'h01e, 11'h023},
    {12'h030, 10'h009, 11'h012, 11'h019},
    {12'h038, 10'h009, 11'h016, 11'h01d},
    {12'h040, 10'h00d, 11'h01a, 11'h021},
    {12'h048, 10'h00d, 11'h01e, 11'h025},
    {12'h050, 10'h011, 11'h022, 11'h029},
    {12'h058, 10'h011, 11'h026, 11'h02d},
    {12'h068, 10'h015, 11'h02e, 11'h035},
    {12'h080, 10'h015, 11'h03a, 11'h041},
    {12'h050, 10'h009, 11'h026, 11'h029},
    {12'h060, 10'h009, 11'h02e, 11'h031},
    {12'h070, 10'h011, 11'h036, 11'h039},
    {12'h080, 10'h011, 11'h03e, 11'h041},
    {12'h090, 10'h019, 11'h046, 11'h049},
    {12'h0a0, 10'h019, 11'h04e, 11'h051},
    {12'h0c0, 10'h021, 11'h05e, 11'h061},
    {12'h0f0, 10'h021, 11'h076, 11'h079},
    {12'h0a0, 10'h011, 11'h04e, 11'h051},
    {12'h0c0, 10'h011, 11'h05e, 11'h061},
    {12'h0e0, 10'h021, 11'h06e, 11'h071},
    {12'h100, 10'h021, 11'h07e, 11'h081},
    {12'h120, 10'h031, 11'h08e, 11'h091},
    {12'h140, 10'h031, 11'h09e, 11'h0a1},
    {12'h180, 10'h041, 11'h0be, 11'h0c1},
    {12'h1e0, 10'h041, 11'h0ee, 11'h0f1},
    {12'h140, 10'h021, 11'h09e, 11'h0a1},
    {12'h180, 10'h021, 11'h0be, 11'h0c1},
    {12'h1c0, 10'h041, 11'h0de, 11'h0e1},
    {12'h200, 10'h041, 11'h0fe, 11'h101},
    {12'h240, 10'h061, 11'h11e, 11'h121},
    {12'h280, 10'h061, 11'h13e, 11'h141},
    {12'h300, 10'h081, 11'h17e, 11'h181},
    {12'h3c0, 10'h081, 11'h1de, 11'h1e1},
    {12'h280, 10'h041, 11'h13e, 11'h141},
    {12'h300, 10'h041, 11'h17e, 11'h181},
    {12'h380, 10'h081, 11'h1be, 11'h1c1},
    {12'h400, 10'h081, 11'h1fe, 11'h201},
    {12'h480, 10'h0c1, 11'h23e, 11'h241},
    {12'h500, 10'h0c1, 11'h27e, 11'h281},
    {12'h600, 10'h101, 11'h2fe, 11'h301},
    {12'h780, 10'h101, 11'h3be, 11'h3c1},
    {12'h500, 10'h081, 11'h27e, 11'h281},
    {12'h600, 10'h081, 11'h2fe, 11'h301},
    {12'h700, 10'h101, 11'h37e, 11'h381},
    {12'h800, 10'h101, 11'h3fe, 11'h401},
    {12'h900, 10'h181, 11'h47e, 11'h481},
    {12'ha00, 10'h181, 11'h4fe, 11'h501},
    {12'hc00, 10'h201, 11'h5fe, 11'h601},
    {12'hf00, 10'h201, 11'h77e, 11'h781}
  };

  // ------------------------------------------------------------
  // Registers
  // ------------------------------------------------------------
  logic [7:0] own_r, own_nxt;
  logic [7:0] rate_r, rate_nxt;
  logic [7:0] rdata_r, rdata_nxt;
  logic       match_r, match_nxt;
  logic [7:0] status;
  ibr_pkg::ibr_state_t st_r, st_nxt;

  always_comb begin
    own_nxt   = own_r;
    rate_nxt  = rate_r;
    rdata_nxt = 8'h00;
    if (reg_wr && reg_addr == ibr_pkg::OFS_OWN_ADDR) begin
      own_nxt = {reg_wdata[7:ibr_pkg::ADDR_LSB], 1'b0};
    end
    if (reg_wr && reg_addr == ibr_pkg::OFS_RATE) begin
      rate_nxt = reg_wdata;
    end
    if (reg_rd) begin
      unique case (reg_addr)
        ibr_pkg::OFS_OWN_ADDR: rdata_nxt = own_r;
        ibr_pkg::OFS_RATE:     rdata_nxt = rate_r;
        ibr_pkg::OFS_STATUS:   rdata_nxt = status;
        default:               rdata_nxt = 8'h00;
      endcase
    end
    // One compare serves the 7-bit address: the seven bits are the
    // whole address, compared with own address bits 7 to 1
    match_nxt = (rx_addr == own_r[7:ibr_pkg::ADDR_LSB]);
  end

  always_ff @(posedge clk) begin
    if (!reset_n) begin
      own_r   <= ibr_pkg::OWN_ADDR_RST;
      rate_r  <= ibr_pkg::RATE_RST;
      rdata_r <= 8'h00;
      match_r <= 1'b0;
    end else if (ce) begin
      own_r   <= own_nxt;
      rate_r  <= rate_nxt;
      rdata_r <= rdata_nxt;
      match_r <= match_nxt;
    end
  end

  // ------------------------------------------------------------
  // Pin synchronisers
  // ------------------------------------------------------------
  logic [2:0] scl_sy_r, scl_sy_nxt;
  logic [2:0] sda_sy_r, sda_sy_nxt;
  logic       scl_lvl_r, scl_lvl_nxt;
  logic       sda_lvl_r, sda_lvl_nxt;

  always_comb begin
    scl_sy_nxt  = {scl_sy_r[1:0], scl_in};
    sda_sy_nxt  = {sda_sy_r[1:0], sda_in};
    scl_lvl_nxt = scl_lvl_r;
    sda_lvl_nxt = sda_lvl_r;
    // Level moves only once stages two and three agree
    if (scl_sy_r[1] == scl_sy_r[2]) begin
      scl_lvl_nxt = scl_sy_r[2];
    end
    if (sda_sy_r[1] == sda_sy_r[2]) begin
      sda_lvl_nxt = sda_sy_r[2];
    end
  end

  always_ff @(posedge clk) begin
    if (!reset_n) begin
      scl_sy_r  <= ibr_pkg::SYNC_RST;
      sda_sy_r  <= ibr_pkg::SYNC_RST;
      scl_lvl_r <= 1'b1;
      sda_lvl_r <= 1'b1;
    end else if (ce) begin
      scl_sy_r  <= scl_sy_nxt;
      sda_sy_r  <= sda_sy_nxt;
      scl_lvl_r <= scl_lvl_nxt;
      sda_lvl_r <= sda_lvl_nxt;
    end
  end

  // ------------------------------------------------------------
  // Rate decode
  // ------------------------------------------------------------
  logic [43:0] ent;
  logic [1:0]  msh;
  logic [13:0] p_cyc, half_cyc, hold_cyc, sth_cyc, sph_cyc;

  always_comb begin
    ent = RATE_TBL[rate_r[ibr_pkg::CODE_MSB:0]];
    // Reserved code 11 falls back to factor 1
    unique case (rate_r[ibr_pkg::FACTOR_MSB:ibr_pkg::FACTOR_LSB])
      ibr_pkg::FACTOR_X2: msh = 2'h1;
      ibr_pkg::FACTOR_X4: msh = 2'h2;
      default:            msh = 2'h0;
    endcase
    p_cyc    = 14'(ent[ibr_pkg::DIV_LSB +: 12]) << msh;
    half_cyc = p_cyc >> 1;
    hold_cyc = 14'(ent[ibr_pkg::SDAH_LSB +: 10]) << msh;
    sth_cyc  = 14'(ent[ibr_pkg::STH_LSB +: 11]) << msh;
    sph_cyc  = 14'(ent[ibr_pkg::SPH_LSB +: 11]) << msh;
  end

  // ------------------------------------------------------------
  // Bus timing engine
  // ------------------------------------------------------------
  logic [13:0] cnt_r, cnt_nxt;
  logic [1:0]  kind_r, kind_nxt;
  logic        bit_r, bit_nxt;
  logic        rx_r, rx_nxt;
  logic        scl_drv_r, scl_drv_nxt;
  logic        sda_drv_r, sda_drv_nxt;
  logic        done, launch;

  assign done   = (cnt_r == 14'h0001);
  assign launch = cmd_valid && cmd_ready;
  assign status = {5'h00, st_r == ibr_pkg::ST_IDLE, sda_lvl_r, scl_lvl_r};

  always_comb begin
    cmd_ready = ce && ((st_r == ibr_pkg::ST_IDLE &&
                        cmd_op == ibr_pkg::IBR_CMD_START) ||
                       st_r == ibr_pkg::ST_PARK ||
                       (st_r == ibr_pkg::ST_HIGH && done &&
                        kind_r != ibr_pkg::IBR_CMD_START));
  end

  always_comb begin
    st_nxt      = st_r;
    cnt_nxt     = cnt_r - 14'h0001;
    kind_nxt    = kind_r;
    bit_nxt     = bit_r;
    rx_nxt      = rx_r;
    scl_drv_nxt = scl_drv_r;
    sda_drv_nxt = sda_drv_r;
    unique case (st_r)
      ibr_pkg::ST_IDLE: begin
        cnt_nxt = cnt_r;
        if (launch) begin
          sda_drv_nxt = 1'b1;
          cnt_nxt     = sth_cyc;
          st_nxt      = ibr_pkg::ST_SHOLD;
        end
      end
      ibr_pkg::ST_SHOLD: if (done) begin
        scl_drv_nxt = 1'b1;
        st_nxt      = ibr_pkg::ST_PARK;
      end
      ibr_pkg::ST_PARK: begin
        cnt_nxt = cnt_r;
        if (launch) begin
          kind_nxt = cmd_op;
          bit_nxt  = cmd_data;
          cnt_nxt  = hold_cyc;
          st_nxt   = ibr_pkg::ST_LOWH;
        end
      end
      ibr_pkg::ST_LOWH: if (done) begin
        // Low for stop or a zero bit, released for a one or restart
        sda_drv_nxt = (kind_r == ibr_pkg::IBR_CMD_STOP) ||
                      (kind_r == ibr_pkg::IBR_CMD_BIT && !bit_r);
        cnt_nxt     = half_cyc - hold_cyc;
        st_nxt      = ibr_pkg::ST_LOWR;
      end
      ibr_pkg::ST_LOWR: if (done) begin
        scl_drv_nxt = 1'b0;
        if (kind_r == ibr_pkg::IBR_CMD_STOP) begin
          cnt_nxt = sph_cyc;
          st_nxt  = ibr_pkg::ST_PHOLD;
        end else begin
          cnt_nxt = p_cyc - half_cyc;
          st_nxt  = ibr_pkg::ST_HIGH;
        end
      end
      ibr_pkg::ST_HIGH: if (done) begin
        if (kind_r == ibr_pkg::IBR_CMD_START) begin
          sda_drv_nxt = 1'b1;
          cnt_nxt     = sth_cyc;
          st_nxt      = ibr_pkg::ST_SHOLD;
        end else begin
          rx_nxt      = sda_lvl_r;
          scl_drv_nxt = 1'b1;
          cnt_nxt     = cnt_r;
          st_nxt      = ibr_pkg::ST_PARK;
          // Back-to-back command keeps the period exact
          if (launch) begin
            kind_nxt = cmd_op;
            bit_nxt  = cmd_data;
            cnt_nxt  = hold_cyc;
            st_nxt   = ibr_pkg::ST_LOWH;
          end
        end
      end
      ibr_pkg::ST_PHOLD: if (done) begin
        sda_drv_nxt = 1'b0;
        st_nxt      = ibr_pkg::ST_IDLE;
      end
      default: begin
        scl_drv_nxt = 1'b0;
        sda_drv_nxt = 1'b0;
        st_nxt      = ibr_pkg::ST_IDLE;
      end
    endcase
  end

  always_ff @(posedge clk) begin
    if (!reset_n) begin
      st_r      <= ibr_pkg::ST_IDLE;
      cnt_r     <= 14'h0001;
      kind_r    <= ibr_pkg::IBR_CMD_BIT;
      bit_r     <= 1'b0;
      rx_r      <= 1'b0;
      scl_drv_r <= 1'b0;
      sda_drv_r <= 1'b0;
    end else if (ce) begin
      st_r      <= st_nxt;
      cnt_r     <= cnt_nxt;
      kind_r    <= kind_nxt;
      bit_r     <= bit_nxt;
      rx_r      <= rx_nxt;
      scl_drv_r <= scl_drv_nxt;
      sda_drv_r <= sda_drv_nxt;
    end
  end

  assign reg_rdata  = rdata_r;
  assign addr_match = match_r;
  assign rx_bit     = rx_r;
  assign scl_out    = 1'b0;
  assign sda_out    = 1'b0;
  assign scl_oe     = scl_drv_r;
  assign sda_oe     = sda_drv_r;

  // ------------------------------------------------------------
  // Checks
  // ------------------------------------------------------------
  logic [13:0] age_r, bage_r;
  logic [6:0]  wd_hi;
  assign wd_hi = reg_wdata[7:1];

  always_ff @(posedge clk) begin
    if (!reset_n) begin
      age_r  <= 14'h0000;
      bage_r <= 14'h0000;
    end else if (ce) begin
      age_r  <= (st_nxt != st_r) ? 14'h0000 : age_r + 14'h0001;
      bage_r <= (st_nxt == ibr_pkg::ST_LOWH && st_r != ibr_pkg::ST_LOWH)
                ? 14'h0000 : bage_r + 14'h0001;
    end
  end

  default clocking cb @(posedge clk); endclocking
  default disable iff (!reset_n);

  AST_SDA_HOLD: assert property (
    ce && st_r == ibr_pkg::ST_LOWH && done |->
      age_r == hold_cyc - 14'h0001)
    else $error("sda hold length wrong");
  AST_SDA_STABLE: assert property (
    st_r == ibr_pkg::ST_LOWH && $past(st_r) == ibr_pkg::ST_LOWH |->
      $stable(sda_oe))
    else $error("sda moved inside hold");
  AST_LOW_HALF: assert property (
    ce && st_r == ibr_pkg::ST_LOWR && done |->
      bage_r == half_cyc - 14'h0001 ##1 !scl_oe)
    else $error("scl low phase wrong");
  AST_PERIOD: assert property (
    ce && st_r == ibr_pkg::ST_HIGH && done &&
    kind_r == ibr_pkg::IBR_CMD_BIT |-> bage_r == p_cyc - 14'h0001)
    else $error("bit period wrong");
  AST_START_SHAPE: assert property (
    st_r == ibr_pkg::ST_SHOLD |-> sda_oe && !scl_oe)
    else $error("start shape wrong");
  AST_START_HOLD: assert property (
    ce && st_r == ibr_pkg::ST_SHOLD && done |->
      age_r == sth_cyc - 14'h0001 ##1 scl_oe)
    else $error("start hold wrong");
  AST_STOP_HOLD: assert property (
    ce && st_r == ibr_pkg::ST_PHOLD && done |->
      age_r == sph_cyc - 14'h0001 && !scl_oe ##1 !sda_oe)
    else $error("stop hold wrong");
  AST_TABLE: assert property (
    rate_r == 8'h00 |-> p_cyc == 14'h0014 && hold_cyc == 14'h0007)
    else $error("code zero table wrong");
  AST_FACTOR: assert property (
    rate_r == 8'h9f |-> p_cyc == 14'h03c0 && sth_cyc == 14'h01d8)
    else $error("multiplier wrong");
  AST_ADDR: assert property (
    ce && reg_wr && reg_addr == ibr_pkg::OFS_OWN_ADDR ##1
    ce && !reg_wr && rx_addr == $past(wd_hi) |=> addr_match)
    else $error("own address not matched");

  COV_START: cover property (ce && st_r == ibr_pkg::ST_SHOLD && done);
  COV_BIT:   cover property (ce && st_r == ibr_pkg::ST_HIGH && done);
  COV_STOP:  cover property (ce && st_r == ibr_pkg::ST_PHOLD && done);
  COV_RSTRT: cover property (st_r == ibr_pkg::ST_HIGH &&
                             kind_r == ibr_pkg::IBR_CMD_START);

endmodule

// File: shared/ibr_pkg.sv
package ibr_pkg;

  // ------------------------------------------------------------
  // Register map and reset values
  // ------------------------------------------------------------
  localparam logic [1:0] OFS_OWN_ADDR = 2'h0;
  localparam logic [1:0] OFS_RATE     = 2'h1;
  localparam logic [1:0] OFS_STATUS   = 2'h2;
  localparam logic [7:0] OWN_ADDR_RST = 8'h00;
  localparam logic [7:0] RATE_RST     = 8'h00;

  // ------------------------------------------------------------
  // Field positions
  // ------------------------------------------------------------
  localparam int ADDR_LSB = 1;
  localparam int FACTOR_MSB = 7;
  localparam int FACTOR_LSB = 6;
  localparam int CODE_MSB   = 5;
  localparam int DIV_LSB  = 32;
  localparam int SDAH_LSB = 22;
  localparam int STH_LSB  = 11;
  localparam int SPH_LSB  = 0;

  // Multiplier codes; code 11 is reserved
  localparam logic [1:0] FACTOR_X1 = 2'h0;
  localparam logic [1:0] FACTOR_X2 = 2'h1;
  localparam logic [1:0] FACTOR_X4 = 2'h2;

  // Pins idle released, so synchronisers start high
  localparam logic [2:0] SYNC_RST = 3'h7;

  typedef enum logic [1:0] {
    IBR_CMD_START = 2'h0,
    IBR_CMD_BIT   = 2'h1,
    IBR_CMD_STOP  = 2'h2
  } ibr_cmd_t;

  typedef enum logic [6:0] {
    ST_IDLE  = 7'h01,
    ST_SHOLD = 7'h02,
    ST_PARK  = 7'h04,
    ST_LOWH  = 7'h08,
    ST_LOWR  = 7'h10,
    ST_HIGH  = 7'h20,
    ST_PHOLD = 7'h40
  } ibr_state_t;

endpackage
